/* uct_regs.svh */
// Constants of the counter/timer: mode codes, widths and reset values
`ifndef UCT_REGS_SVH
`define UCT_REGS_SVH

`define UCT_CNT_W 16
`define UCT_BYTE_W 8
`define UCT_MODE_W 3
`define UCT_PRE_W 4
`define UCT_NSRC 4
`define UCT_SRC_IP2 2'd0
`define UCT_SRC_XTAL 2'd1
`define UCT_SRC_TXA 2'd2
`define UCT_SRC_TXB 2'd3
`define UCT_MODE_TIMER_BIT 2
`define UCT_MODE_C_IP2 3'h0
`define UCT_MODE_C_TXA 3'h1
`define UCT_MODE_C_TXB 3'h2
`define UCT_MODE_C_X16 3'h3
`define UCT_MODE_T_IP2 3'h4
`define UCT_MODE_T_I16 3'h5
`define UCT_MODE_T_XTAL 3'h6
`define UCT_MODE_T_X16 3'h7
`define UCT_CNT_RST 16'h0000
`define UCT_CNT_ONE 16'h0001
`define UCT_PRE_RST 8'h00
`define UCT_PRE_MAX 4'hf
`define UCT_PRE_ZERO 4'h0

`endif

/* uct_pkg.sv */
// Types shared by the counter/timer
package uct_pkg;

  typedef enum logic [1:0] {
    UCT_IDLE = 2'b01,
    UCT_RUN  = 2'b10
  } uct_run_e;

  typedef struct packed {
    logic we_high;
    logic we_low;
    logic [7:0] data;
  } uct_wr_s;

  typedef struct packed {
    logic start;
    logic stop;
  } uct_cmd_s;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } uct_count_s;

endpackage

/* uct_counter_timer.sv */
// Counter/timer: timer square wave, one-shot counter, preload bytes and commands
`timescale 1ns/100ps
`default_nettype none
`include "uct_regs.svh"

// How it works
// - Timer wave period is twice the preload value in counter-clock periods.
// - A new preload in timer mode takes effect at the next half-period.
// - Timer runs freely; start command restarts the cycle from the preload.
// - Stop in timer mode clears the ready flag, wave keeps running.
// - Timer mode sets the ready flag once per square-wave cycle.
// - Output three carries the timer wave when selected as counter output.
// - Counter mode decrements once per counter-clock pulse from the preload.
// - Counter waits for start; a start reloads from the preload unless a stop comes with it while running.
// - Counter reaching zero sets the ready flag.
// - After terminal count the counter keeps decrementing and wraps until stopped.
// - Output three stays high until terminal count, then goes low.
// - Stop halts counting, sets output three high, clears the ready flag.
// - Preload rewrites in counter mode apply only at the next start.
// - Preload is kept, so a bare start reuses the previous value.
// - Live count is readable as separate upper and lower bytes.
// - Three-bit mode field picks mode and counter clock source.
// - Preload lives in a high byte register and a low byte register.
// - Interrupt request asserts while ready flag and its mask are both one.
module uct_counter_timer (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic general_input_two,
  input wire logic crystal_clock_in,
  input wire logic tx_a_bit_clock,
  input wire logic tx_b_bit_clock,
  input wire logic [2:0] auxiliary_control,
  input wire uct_pkg::uct_wr_s preload_wr,
  input wire uct_pkg::uct_cmd_s cmd,
  input wire logic interrupt_mask,
  input wire logic op3_select_ct,
  input wire logic op3_port_value,
  output logic interrupt_status,
  output logic interrupt_request_n,
  output uct_pkg::uct_count_s count_value,
  output logic [7:0] preload_high_byte,
  output logic [7:0] preload_low_byte,
  output logic general_output_three
);
  import uct_pkg::*;

  // Counter clock pins, each through its own synchroniser and edge detector
  logic rise_ip2;
  logic rise_xtal;
  logic rise_txa;
  logic rise_txb;
  logic ip2_16;
  logic xtal_16;
  uct_pin_edge #(
    .IDLE_LVL(1'b0)
  ) u_edge_ip2 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin(general_input_two),
    .rise(rise_ip2)
  );
  uct_pin_edge #(
    .IDLE_LVL(1'b0)
  ) u_edge_xtal (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin(crystal_clock_in),
    .rise(rise_xtal)
  );
  uct_pin_edge #(
    .IDLE_LVL(1'b0)
  ) u_edge_txa (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin(tx_a_bit_clock),
    .rise(rise_txa)
  );
  uct_pin_edge #(
    .IDLE_LVL(1'b0)
  ) u_edge_txb (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin(tx_b_bit_clock),
    .rise(rise_txb)
  );

  // Divide-by-16 prescalers on the input-two and crystal edges
  uct_pulse_div #(
    .W(`UCT_PRE_W)
  ) u_div_ip2 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pulse(rise_ip2),
    .pulse_out(ip2_16)
  );
  uct_pulse_div #(
    .W(`UCT_PRE_W)
  ) u_div_xtal (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pulse(rise_xtal),
    .pulse_out(xtal_16)
  );

  // Mode and clock source select
  wire timer_mode = auxiliary_control[`UCT_MODE_TIMER_BIT];
  wire sel_c_ip2 = (auxiliary_control == `UCT_MODE_C_IP2);
  wire sel_c_txa = (auxiliary_control == `UCT_MODE_C_TXA);
  wire sel_c_txb = (auxiliary_control == `UCT_MODE_C_TXB);
  wire sel_c_x16 = (auxiliary_control == `UCT_MODE_C_X16);
  wire sel_t_ip2 = (auxiliary_control == `UCT_MODE_T_IP2);
  wire sel_t_i16 = (auxiliary_control == `UCT_MODE_T_I16);
  wire sel_t_xtal = (auxiliary_control == `UCT_MODE_T_XTAL);
  wire sel_t_x16 = (auxiliary_control == `UCT_MODE_T_X16);
  wire tick = (sel_c_ip2 & rise_ip2) |
              (sel_c_txa & rise_txa) |
              (sel_c_txb & rise_txb) |
              (sel_c_x16 & xtal_16) |
              (sel_t_ip2 & rise_ip2) |
              (sel_t_i16 & ip2_16) |
              (sel_t_xtal & rise_xtal) |
              (sel_t_x16 & xtal_16);

  // Preload byte registers, kept across cycles
  logic [7:0] pre_hi_r;
  logic [7:0] pre_lo_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_hi_r <= `UCT_PRE_RST;
      pre_lo_r <= `UCT_PRE_RST;
    end else begin
      if (preload_wr.we_high) pre_hi_r <= preload_wr.data;
      if (preload_wr.we_low) pre_lo_r <= preload_wr.data;
    end
  end
  wire [`UCT_CNT_W-1:0] preload = {pre_hi_r, pre_lo_r};

  // Counting core
  logic [`UCT_CNT_W-1:0] cnt_r;
  logic [`UCT_CNT_W-1:0] cnt_nxt;
  uct_run_e run_r;
  uct_run_e run_nxt;
  logic wave_r;
  logic wave_nxt;
  logic tc_r;
  logic tc_nxt;
  logic ready_r;
  logic ready_set;

  wire at_edge = (cnt_r == `UCT_CNT_ONE) || (cnt_r == `UCT_CNT_RST);
  wire [`UCT_CNT_W-1:0] cnt_dec = cnt_r - `UCT_CNT_ONE;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    wave_nxt = wave_r;
    tc_nxt = tc_r;
    ready_set = 1'b0;
    if (timer_mode) begin
      run_nxt = UCT_IDLE;
      tc_nxt = 1'b0;
      if (cmd.start) begin
        cnt_nxt = preload;
        wave_nxt = 1'b1;
      end else if (tick) begin
        if (at_edge) begin
          // Reload only at the half-period boundary so a rewrite waits its turn
          cnt_nxt = preload;
          wave_nxt = ~wave_r;
          ready_set = wave_r;
        end else begin
          cnt_nxt = cnt_dec;
        end
      end
    end else begin
      wave_nxt = 1'b1;
      case (run_r)
        UCT_IDLE: begin
          if (cmd.start) begin
            cnt_nxt = preload;
            run_nxt = UCT_RUN;
            tc_nxt = 1'b0;
          end
        end
        UCT_RUN: begin
          if (cmd.stop) begin
            run_nxt = UCT_IDLE;
            tc_nxt = 1'b0;
          end else if (cmd.start) begin
            cnt_nxt = preload;
            tc_nxt = 1'b0;
          end else if (tick) begin
            cnt_nxt = cnt_dec;
            if (cnt_r == `UCT_CNT_ONE) begin
              tc_nxt = 1'b1;
              ready_set = 1'b1;
            end
          end
        end
        default: run_nxt = UCT_IDLE;
      endcase
    end
  end

  // Set beats a stop landing in the same cycle; only timer mode can set while a stop lands
  wire ready_nxt = ready_set | (ready_r & ~cmd.stop);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= `UCT_CNT_RST;
      run_r <= UCT_IDLE;
      wave_r <= 1'b1;
      tc_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      wave_r <= wave_nxt;
      tc_r <= tc_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Output three: timer wave, or high until terminal count in counter mode
  logic op3_r;
  wire ct_out = timer_mode ? wave_r : ~tc_r;
  wire op3_nxt = op3_select_ct ? ct_out : op3_port_value;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      op3_r <= 1'b1;
    end else begin
      op3_r <= op3_nxt;
    end
  end

  assign general_output_three = op3_r;
  assign interrupt_status = ready_r;
  assign interrupt_request_n = ~(ready_r & interrupt_mask);
  // Halves are live; a borrow may fall between two reads unless stopped first
  assign count_value.high = cnt_r[15:8];
  assign count_value.low = cnt_r[7:0];
  assign preload_high_byte = pre_hi_r;
  assign preload_low_byte = pre_lo_r;

endmodule // uct_counter_timer

// Two-flop synchroniser with a rising-edge detector on the second flop
module uct_pin_edge #(
  // Resetting to the pin's idle level keeps a false edge from following reset
  parameter logic IDLE_LVL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pin,
  output logic rise
);
  import uct_pkg::*;
  logic meta_r;
  logic sync_r;
  logic last_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= IDLE_LVL;
      sync_r <= IDLE_LVL;
      last_r <= IDLE_LVL;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end
  // Nothing but the second flop reads the first
  assign rise = sync_r & ~last_r;
endmodule // uct_pin_edge

// Passes every sixteenth one-cycle pulse of a synchronised edge train
module uct_pulse_div #(
  parameter int W = `UCT_PRE_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pulse,
  output logic pulse_out
);
  import uct_pkg::*;
  logic [W-1:0] div_r;
  logic [W-1:0] div_nxt;
  assign div_nxt = div_r + {{(W-1){1'b0}}, pulse};
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= `UCT_PRE_ZERO;
    end else begin
      div_r <= div_nxt;
    end
  end
  // The output is the input pulse itself, so it keeps its one-cycle width
  assign pulse_out = pulse && (div_r == `UCT_PRE_MAX);
endmodule // uct_pulse_div
`default_nettype wire

/* uct_counter_timer_chk.sv */
// Port assertions for the counter/timer
`timescale 1ns/100ps
`default_nettype none
module uct_counter_timer_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [2:0] auxiliary_control,
  input wire uct_pkg::uct_wr_s preload_wr,
  input wire uct_pkg::uct_cmd_s cmd,
  input wire logic interrupt_mask,
  input wire logic op3_select_ct,
  input wire logic op3_port_value,
  input wire logic interrupt_status,
  input wire logic interrupt_request_n,
  input wire uct_pkg::uct_count_s count_value,
  input wire logic [7:0] preload_high_byte,
  input wire logic [7:0] preload_low_byte,
  input wire logic general_output_three
);
  import uct_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire logic cm = !auxiliary_control[2];
  a_irq_gate: assert property (interrupt_request_n == !(interrupt_status && interrupt_mask))
    else $error("irq gate wrong");
  a_wr_high: assert property (preload_wr.we_high |=> preload_high_byte == $past(preload_wr.data))
    else $error("high byte not written");
  a_wr_low: assert property (preload_wr.we_low |=> preload_low_byte == $past(preload_wr.data))
    else $error("low byte not written");
  a_start_load: assert property (cmd.start && !cmd.stop |=>
    count_value == $past({preload_high_byte, preload_low_byte})) else $error("start no reload");
  a_stop_clear: assert property (cmd.stop && cm |=> !interrupt_status)
    else $error("stop kept ready");
  a_tc_low: assert property ($rose(interrupt_status) && cm && op3_select_ct && !cmd.stop
    |=> !general_output_three) else $error("output not low at tc");
  a_stop_high: assert property (cmd.stop && !cmd.start && cm && op3_select_ct
    |-> ##2 general_output_three) else $error("output not high after stop");
  a_port_mux: assert property (!op3_select_ct && $past(!op3_select_ct) && $past(resetn)
    |-> general_output_three == $past(op3_port_value)) else $error("port value not shown");
endmodule // uct_counter_timer_chk
`default_nettype wire

/* uct_pin_src.sv */
// External counter clock pin source
`timescale 1ns/100ps
`default_nettype none
module uct_pin_src (
  input wire logic clk,
  input wire logic fire,
  output logic pin
);
  logic [3:0] ph_r = 4'h0;
  // Pulses long enough to pass the pin synchroniser
  always @(posedge clk) begin
    if (fire) ph_r <= 4'h8;
    else if (ph_r != 4'h0) ph_r <= ph_r - 4'h1;
  end
  assign pin = ph_r[3] | ph_r[2];
endmodule // uct_pin_src
`default_nettype wire

/* uct_counter_timer_tb.sv */
// Testbench for the counter/timer
`timescale 1ns/100ps
`default_nettype none
module uct_counter_timer_tb;
  import uct_pkg::*;
  logic clk = 0, rstn = 0, ip2, xt, txa, txb, st, irqn, o3, mask = 1, sel = 1, pv = 1;
  logic [3:0] fire = 4'h0;
  logic [3:0] fsel = 4'h1;
  logic [2:0] ac = 3'h0;
  logic [7:0] ph, pl;
  uct_wr_s wr = '0;
  uct_cmd_s cmd = '0;
  uct_count_s cnt;
  int errors = 0, checks_done = 0;
  initial forever #2.5 clk = ~clk;
  // One source per clock pin: bit 0 input two, 1 crystal, 2 and 3 the bit clocks
  uct_pin_src src_ip2 (.clk(clk), .fire(fire[0]), .pin(ip2));
  uct_pin_src src_xt (.clk(clk), .fire(fire[1]), .pin(xt));
  uct_pin_src src_txa (.clk(clk), .fire(fire[2]), .pin(txa));
  uct_pin_src src_txb (.clk(clk), .fire(fire[3]), .pin(txb));
  uct_counter_timer dut (.ref_clk(clk), .resetn(rstn), .general_input_two(ip2),
    .crystal_clock_in(xt), .tx_a_bit_clock(txa), .tx_b_bit_clock(txb),
    .auxiliary_control(ac), .preload_wr(wr), .cmd(cmd), .interrupt_mask(mask),
    .op3_select_ct(sel), .op3_port_value(pv), .interrupt_status(st),
    .interrupt_request_n(irqn), .count_value(cnt), .preload_high_byte(ph),
    .preload_low_byte(pl), .general_output_three(o3));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wrb(input logic hi, input logic [7:0] d);
    @(posedge clk) #1 wr = '{hi, !hi, d};
    @(posedge clk) #1 wr = '0;
  endtask
  task cmdp(input logic s, input logic p);
    @(posedge clk) #1 cmd = '{s, p};
    @(posedge clk) #1 cmd = '0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task tick;
    @(posedge clk) #1 fire = fsel;
    @(posedge clk) #1 fire = 4'h0;
    repeat (10) @(posedge clk);
    #1;
  endtask
  // Preload is 0003 here: the other pins must not count, n selected edges count once
  task mode_chk(input logic [2:0] m, input logic [3:0] s, input int n);
    ac = m;
    cmdp(1, 0);
    fsel = ~s;
    tick;
    fsel = s;
    repeat (n) tick;
    chk(cnt, 16'h0002);
  endtask
  task end_sim;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rstn = 1;
    chk({st, irqn, o3}, 3'b011);
    wrb(1, 8'h00);
    wrb(0, 8'h03);
    chk({ph, pl}, 16'h0003);
    cmdp(1, 0);
    chk(cnt, 16'h0003);
    tick;
    chk(cnt, 16'h0002);
    wrb(0, 8'h05);
    tick;
    chk(cnt, 16'h0001);
    tick;
    chk(cnt, 16'h0000);
    chk({st, irqn, o3}, 3'b100);
    tick;
    chk(cnt, 16'hffff);
    cmdp(0, 1);
    chk({st, irqn, o3}, 3'b011);
    tick;
    chk(cnt, 16'hffff);
    cmdp(1, 0);
    chk(cnt, 16'h0005);
    tick;
    cmdp(0, 1);
    cmdp(1, 0);
    chk(cnt, 16'h0005);
    wrb(1, 8'h01);
    cmdp(1, 0);
    chk({cnt.high, cnt.low}, 16'h0105);
    ac = 3'h4;
    wrb(1, 8'h00);
    wrb(0, 8'h02);
    cmdp(1, 0);
    tick;
    cmdp(1, 0);
    tick;
    chk(o3, 1);
    tick;
    chk({st, o3}, 2'b10);
    cmdp(0, 1);
    chk({st, o3}, 2'b00);
    wrb(0, 8'h03);
    tick;
    tick;
    chk({st, o3}, 2'b01);
    repeat (2) tick;
    chk({st, o3}, 2'b01);
    tick;
    chk({st, o3}, 2'b10);
    sel = 0;
    pv = 0;
    repeat (3) @(posedge clk);
    #1 chk(o3, 0);
    mode_chk(3'h1, 4'h4, 1);
    mode_chk(3'h2, 4'h8, 1);
    mode_chk(3'h3, 4'h2, 16);
    mode_chk(3'h5, 4'h1, 16);
    mode_chk(3'h6, 4'h2, 1);
    mode_chk(3'h7, 4'h2, 16);
    end_sim;
  end
endmodule // uct_counter_timer_tb
bind uct_counter_timer uct_counter_timer_chk chk_i (.ref_clk, .resetn, .auxiliary_control,
  .preload_wr, .cmd, .interrupt_mask, .op3_select_ct, .op3_port_value, .interrupt_status,
  .interrupt_request_n, .count_value, .preload_high_byte, .preload_low_byte,
  .general_output_three);
`default_nettype wire
